// >>> src/ref_ladder_map.svh
/*
  Register map, field positions and reset values of the reference ladder
  control block. Assumes inclusion by bare name from the design files.
*/
`ifndef REF_LADDER_MAP_SVH
`define REF_LADDER_MAP_SVH

`define REF_CTRL_ADDR      4'h0
`define REF_MODE_ADDR      4'h1
`define REF_STAT_ADDR      4'h2
`define REF_CTRL_RESET     8'h00
`define REF_MODE_RESET     3'h7
`define REF_EN_BIT         7
`define REF_OE_BIT         6
`define REF_RANGE_BIT      5
`define REF_SRC_BIT        4
`define REF_LEVEL_MSB      3
`define REF_MODE_REF_CODE  3'h6
`define REF_MODE_MSB       2
`define REF_DIR_INPUT      1'b1
`define REF_ADDR_W         4
`define REF_DATA_W         8

`endif

// >>> src/ref_ladder_pkg.sv
/*
  Types shared by the reference ladder control design.
  Assumes the map header is compiled alongside.
*/
package ref_ladder_pkg;
  typedef logic [3:0]  level_t;
  typedef logic [15:0] tap_t;
  typedef logic [7:0]  byte_t;
endpackage

// >>> src/ref_tap_decoder.sv
/*
  One-hot decoder from the level field to sixteen ladder tap selects.
  Assumes a registered, stable level input.
*/
`timescale 1ns/1ps
`default_nettype none
module ref_tap_decoder
(
  input  wire ref_ladder_pkg::level_t levelSel,
  input  wire logic                   enable,
  output var  ref_ladder_pkg::tap_t   tapOneHot
);
  import ref_ladder_pkg::*;

  always_comb
  begin
    tapOneHot = '0;
    if (enable)
    begin
      tapOneHot[levelSel] = 1'b1; // see RULE6
    end
  end
endmodule
`default_nettype wire

// >>> src/ref_ladder_control.sv
/*
  Control logic for the comparator reference resistor ladder: holds the
  ladder control register and drives power, tap, range, source and pin
  controls from flip-flops. Assumes a plain strobe register port whose
  master never issues read and write together, and a sleep state that
  keeps the clock or simply stops it without reset.
*/
// Behaviour
// RULE1 - Enable bit seven powers the ladder
// RULE2 - Bit six connects reference to pin two
// RULE3 - Pin output overrides port direction bit
// RULE4 - Bit five picks low or high range
// RULE5 - Bit four picks external or supply source
// RULE6 - Level field selects one of sixteen taps
// RULE7 - Reset clears the whole control register
// RULE8 - Sleep wake-up keeps register contents
// RULE9 - Works whatever the comparator mode is
// RULE10 - Software should disable reference before sleep
// RULE11 - Comparators get reference only in mode 110
// RULE12 - Disabled ladder forces taps and pin inactive
`timescale 1ns/1ps
`default_nettype none
`include "ref_ladder_map.svh"
module ref_ladder_control
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic [3:0]            regAddr,
  input  wire ref_ladder_pkg::byte_t regWrData,
  input  wire logic                  regWrStb,
  input  wire logic                  regRdStb,
  input  wire logic                  portADirPin2,
  output var  ref_ladder_pkg::byte_t regRdData,
  output logic                       ladderPowerOn,
  output logic [15:0]                ladderTapSel,
  output logic                       rangeLowSel,
  output logic                       sourceExtSel,
  output logic                       pin2RefConnect,
  output logic                       pin2DirEffective,
  output logic                       compRefFeed
);
  import ref_ladder_pkg::*;

  byte_t  ctrl_reg;
  byte_t  ctrl_next;
  logic [2:0] mode_reg;
  logic [2:0] mode_next;
  byte_t  rd_reg;
  byte_t  rd_next;
  tap_t   tap_reg;
  tap_t   tapDecoded;
  logic   pwr_reg;
  logic   rng_reg;
  logic   src_reg;
  logic   pin_reg;
  logic   dir_reg;
  logic   feed_reg;
  logic   pwr_next;
  tap_t   tap_next;
  logic   rng_next;
  logic   src_next;
  logic   pin_next;
  logic   dir_next;
  logic   feed_next;
  logic   enNow;

  function automatic logic hit(input logic [`REF_ADDR_W-1:0] a,
                               input logic [`REF_ADDR_W-1:0] b);
    hit = (a == b);
  endfunction

  // Write and read-data paths; software-only register so there is no set/clear race.
  always_comb
  begin
    ctrl_next = ctrl_reg;
    mode_next = mode_reg;
    if (regWrStb && hit(regAddr, `REF_CTRL_ADDR))
    begin
      ctrl_next = regWrData;
    end
    if (regWrStb && hit(regAddr, `REF_MODE_ADDR))
    begin
      mode_next = regWrData[`REF_MODE_MSB:0];
    end
    rd_next = '0;
    if (regRdStb)
    begin
      unique case (1'b1)
        hit(regAddr, `REF_CTRL_ADDR): rd_next = ctrl_reg;
        hit(regAddr, `REF_MODE_ADDR): rd_next = {5'h00, mode_reg};
        hit(regAddr, `REF_STAT_ADDR):
          rd_next = {5'h00, feed_reg, pin_reg, pwr_reg};
        default: rd_next = '0;
      endcase
    end
  end

  // Sleep has no reset path, so contents survive wake-up.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_reg <= `REF_CTRL_RESET; // see RULE7
      mode_reg <= `REF_MODE_RESET;
      rd_reg   <= '0;
    end
    else
    begin
      ctrl_reg <= ctrl_next; // see RULE8
      mode_reg <= mode_next;
      rd_reg   <= rd_next;
    end
  end

  assign enNow = ctrl_reg[`REF_EN_BIT];

  ref_tap_decoder u_dec
  (
    .levelSel  (ctrl_reg[`REF_LEVEL_MSB:0]),
    .enable    (enNow),
    .tapOneHot (tapDecoded)
  );

  // Outputs are registered; they trail the register by one cycle.
  // Mode only gates the comparator feed, never ladder or pin.
  always_comb
  begin
    pwr_next  = enNow; // see RULE1, RULE9
    tap_next  = tapDecoded; // see RULE6, RULE12
    rng_next  = ctrl_reg[`REF_RANGE_BIT]; // see RULE4
    src_next  = ctrl_reg[`REF_SRC_BIT]; // see RULE5
    pin_next  = enNow & ctrl_reg[`REF_OE_BIT]; // see RULE2, RULE12
    // Override forces the pin to input so the digital driver is off.
    dir_next  = ctrl_reg[`REF_OE_BIT] ? `REF_DIR_INPUT : portADirPin2;
    feed_next = enNow & (mode_reg == `REF_MODE_REF_CODE); // see RULE11
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwr_reg  <= 1'b0;
      tap_reg  <= '0;
      rng_reg  <= 1'b0;
      src_reg  <= 1'b0;
      pin_reg  <= 1'b0;
      dir_reg  <= `REF_DIR_INPUT;
      feed_reg <= 1'b0;
    end
    else
    begin
      pwr_reg  <= pwr_next;
      tap_reg  <= tap_next;
      rng_reg  <= rng_next;
      src_reg  <= src_next;
      pin_reg  <= pin_next;
      dir_reg  <= dir_next; // see RULE3
      feed_reg <= feed_next;
    end
  end

  assign regRdData        = rd_reg;
  assign ladderPowerOn    = pwr_reg;
  assign ladderTapSel     = tap_reg;
  assign rangeLowSel      = rng_reg;
  assign sourceExtSel     = src_reg;
  assign pin2RefConnect   = pin_reg;
  assign pin2DirEffective = dir_reg;
  assign compRefFeed      = feed_reg;

  AST_POWER: assert property ( // see RULE1
    @(posedge sys_clk) disable iff (!rst_b)
    ladderPowerOn == $past(ctrl_reg[`REF_EN_BIT]))
    else $error("Ladder power does not follow enable bit.");

  AST_PIN: assert property ( // see RULE2
    @(posedge sys_clk) disable iff (!rst_b)
    pin2RefConnect ==
      $past(ctrl_reg[`REF_EN_BIT] & ctrl_reg[`REF_OE_BIT]))
    else $error("Pin connection does not follow enable and output bits.");

  // The first edge out of reset still shows the reset value, so skip it.
  AST_DIR: assert property ( // see RULE3
    @(posedge sys_clk) disable iff (!rst_b)
    $past(rst_b) |-> pin2DirEffective ==
      ($past(ctrl_reg[`REF_OE_BIT]) ? `REF_DIR_INPUT : $past(portADirPin2)))
    else $error("Effective pin direction wrong.");

  AST_RANGE: assert property ( // see RULE4
    @(posedge sys_clk) disable iff (!rst_b)
    rangeLowSel == $past(ctrl_reg[`REF_RANGE_BIT]))
    else $error("Range select wrong.");

  AST_SRC: assert property ( // see RULE5
    @(posedge sys_clk) disable iff (!rst_b)
    sourceExtSel == $past(ctrl_reg[`REF_SRC_BIT]))
    else $error("Source select wrong.");

  AST_TAP: assert property ( // see RULE6
    @(posedge sys_clk) disable iff (!rst_b)
    $past(ctrl_reg[`REF_EN_BIT]) |->
      ladderTapSel == (tap_t'(1) << $past(ctrl_reg[`REF_LEVEL_MSB:0])))
    else $error("Tap select not matching level.");

  AST_OFF: assert property ( // see RULE12
    @(posedge sys_clk) disable iff (!rst_b)
    !$past(ctrl_reg[`REF_EN_BIT]) |->
      ((ladderTapSel == '0) && !pin2RefConnect))
    else $error("Outputs active while disabled.");

  AST_WRITE: assert property ( // see RULE8
    @(posedge sys_clk) disable iff (!rst_b)
    regWrStb && hit(regAddr, `REF_CTRL_ADDR) |=>
      ctrl_reg == $past(regWrData))
    else $error("Control write not stored.");

  AST_HOLD: assert property ( // see RULE8
    @(posedge sys_clk) disable iff (!rst_b)
    !regWrStb |=> $stable(ctrl_reg))
    else $error("Control register changed without a write.");

  AST_FEED: assert property ( // see RULE11
    @(posedge sys_clk) disable iff (!rst_b)
    compRefFeed ==
      $past(ctrl_reg[`REF_EN_BIT] && (mode_reg == `REF_MODE_REF_CODE)))
    else $error("Comparator feed does not follow enable and mode.");

  AST_READ: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    regRdStb && hit(regAddr, `REF_CTRL_ADDR) |=>
      regRdData == $past(ctrl_reg))
    else $error("Control read back wrong.");

  AST_RD_IDLE: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    !regRdStb |=> regRdData == '0)
    else $error("Read data not zero outside a read.");
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
/*
  Self-checking bench for the reference ladder control block.
  Assumes the design package, the map header and the design sources.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ref_ladder_map.svh"
`define CHK(nm, ex, got) check(nm, 16'(ex), 16'(got))
module tb_top;
  import ref_ladder_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [3:0] regAddr = 4'h0;
  byte_t      regWrData = 8'h00;
  logic       regWrStb = 1'b0;
  logic       regRdStb = 1'b0;
  logic       portADirPin2 = 1'b0;
  byte_t      regRdData;
  byte_t      rdVal;
  tap_t       ladderTapSel;
  logic       ladderPowerOn, rangeLowSel, sourceExtSel;
  logic       pin2RefConnect, pin2DirEffective, compRefFeed;
  int         err_total = 0;
  int         samples_checked = 0;

  ref_ladder_control uut (.sys_clk(sys_clk), .rst_b(rst_b),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .portADirPin2(portADirPin2),
    .regRdData(regRdData), .ladderPowerOn(ladderPowerOn),
    .ladderTapSel(ladderTapSel), .rangeLowSel(rangeLowSel),
    .sourceExtSel(sourceExtSel), .pin2RefConnect(pin2RefConnect),
    .pin2DirEffective(pin2DirEffective), .compRefFeed(compRefFeed));

  always #2.5 sys_clk = ~sys_clk;

  task automatic check(input string nm, input logic [15:0] ex, got);
    samples_checked++;
    if (got !== ex)
    begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, ex, got);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input byte_t d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output byte_t d);
    @(posedge sys_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1 d = regRdData;
  endtask

  // Outputs are registered after the control register, so wait two edges.
  task automatic outs(input logic p, input tap_t t, input logic r, s, c, d);
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("power", p, ladderPowerOn);
    `CHK("taps", t, ladderTapSel);
    `CHK("range", r, rangeLowSel);
    `CHK("source", s, sourceExtSel);
    `CHK("pin", c, pin2RefConnect);
    `CHK("dir", d, pin2DirEffective);
  endtask

  initial
  begin
    #20000;
    err_total++;
    complete_run();
  end

  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(`REF_CTRL_ADDR, rdVal);
    `CHK("ctrl rst", 8'h00, rdVal);
    rd(`REF_MODE_ADDR, rdVal);
    `CHK("mode rst", 8'h07, rdVal);
    outs(0, 16'h0, 0, 0, 0, 0);
    wr(`REF_CTRL_ADDR, 8'hc5);
    outs(1, 16'h0020, 0, 0, 1, 1);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge sys_clk);
      portADirPin2 <= i[0];
      wr(`REF_CTRL_ADDR, {4'hb, 4'(i)});
      outs(1, 16'(1 << i), 1, 1, 0, i[0]);
      rd(`REF_CTRL_ADDR, rdVal);
      `CHK("ctrl rd", {4'hb, 4'(i)}, rdVal);
    end
    wr(`REF_CTRL_ADDR, 8'h7f);
    outs(0, 16'h0, 1, 1, 0, 1);
    wr(`REF_CTRL_ADDR, 8'hc0);
    wr(`REF_MODE_ADDR, 8'h06);
    outs(1, 16'h0001, 0, 0, 1, 1);
    `CHK("feed 110", 1'b1, compRefFeed);
    rd(`REF_STAT_ADDR, rdVal);
    `CHK("status", 8'h07, rdVal);
    rd(`REF_MODE_ADDR, rdVal);
    `CHK("mode rd", 8'h06, rdVal);
    wr(`REF_MODE_ADDR, 8'h05);
    outs(1, 16'h0001, 0, 0, 1, 1);
    `CHK("feed 101", 1'b0, compRefFeed);
    wr(4'h5, 8'hff);
    rd(4'h5, rdVal);
    `CHK("unmapped", 8'h00, rdVal);
    repeat (20) @(posedge sys_clk);
    rd(`REF_CTRL_ADDR, rdVal);
    `CHK("ctrl kept", 8'hc0, rdVal);
    wr(`REF_CTRL_ADDR, 8'h00);
    outs(0, 16'h0, 0, 0, 0, 1);
    wr(`REF_CTRL_ADDR, 8'hdf);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(`REF_CTRL_ADDR, rdVal);
    `CHK("ctrl rst2", 8'h00, rdVal);
    wr(`REF_CTRL_ADDR, 8'h80);
    outs(1, 16'h0001, 0, 0, 0, 1);
    `CHK("feed rst", 1'b0, compRefFeed);
    complete_run();
  end
endmodule
`default_nettype wire
